// ===== serdes_sync_ddc_defines.svh
/*
 * Register offsets, field positions, reset values and PLL multiplication factors of the
 * serial PLL, SYSREF mask and decimation page configuration block.
 * Assumes it is included by bare name; it holds definitions only.
 */
`ifndef SERDES_SYNC_DDC_DEFINES_SVH
`define SERDES_SYNC_DDC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Address map (16-bit direct addressing)
// ----------------------------------------------------------------------------
`define JESD_PAGE_BASE          16'h6000
`define PAGE_WINDOW_MASK        16'hF800
`define DDC_PAGE_BASE_A         16'h5000
`define DDC_PAGE_BASE_B         16'h5800
`define SERIAL_PLL_MULT_OFS     16'h0037
`define SYNC_PULSE_MASK_OFS     16'h003E
`define DDC_ENABLE_OFS          11'h000
`define DECIM_RATIO_OFS         11'h001

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define PLL_MULT_LSB            0
`define PLL_MULT_W              2
`define DIV_SYNC_MASK_BIT       6
`define OSC_SYNC_MASK_BIT       5
`define DDC_ENABLE_BIT          0
`define DECIM_RATIO_LSB         0
`define DECIM_RATIO_W           4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PLL_MULT_RST            2'h0
`define SYNC_MASK_RST           1'h0
`define DDC_ENABLE_RST          1'h0
`define DECIM_RATIO_RST         4'h0
`define RDATA_RST               8'h00

// ----------------------------------------------------------------------------
// Multiplication factors per PLL code
// ----------------------------------------------------------------------------
`define PLL_FACTOR_00           7'h14
`define PLL_FACTOR_01           7'h10
`define PLL_FACTOR_10           7'h28
`define PLL_FACTOR_11           7'h50

`endif

// ===== serdes_sync_ddc_pkg.sv
/*
 * Types and decode functions shared by the configuration top and the
 * per-channel decimation page. Assumes the defines header is available.
 */
`include "serdes_sync_ddc_defines.svh"

package serdes_sync_ddc_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic [1:0] pll_code_t;
    typedef logic [3:0] decim_code_t;
    typedef logic [5:0] decimation_ratio_t;

    // Complex decimation factor per code; zero marks a code never accepted
    function automatic decimation_ratio_t decimation_ratio(input decim_code_t code);
        decimation_ratio_t f;
        f = 6'h00;
        case (code)
            4'h0:    f = 6'h04;
            4'h1:    f = 6'h06;
            4'h2:    f = 6'h08;
            4'h3:    f = 6'h09;
            4'h4:    f = 6'h0A;
            4'h5:    f = 6'h0C;
            4'h9:    f = 6'h14;
            4'hC:    f = 6'h20;
            default: f = 6'h00;
        endcase
        return f;
    endfunction : decimation_ratio

    // A code is legal when it maps to a defined factor
    function automatic logic decim_code_ok(input decim_code_t code);
        return (decimation_ratio(code) != 6'h00);
    endfunction : decim_code_ok

endpackage : serdes_sync_ddc_pkg

// ===== ddc_page_if.sv
/*
 * Carrier between the register hub and one decimation page instance.
 * Assumes the hub has already decoded the channel window.
 */
`timescale 1ns/10ps

interface ddc_page_if;
    logic                                wr;
    logic                                rd;
    logic [10:0]                         ofs;
    logic [7:0]                          wdata;
    logic [7:0]                          rdata;
    logic                                enable;
    serdes_sync_ddc_pkg::decim_code_t    ratio;

    modport hub  (output wr, output rd, output ofs, output wdata,
                  input rdata, input enable, input ratio);
    modport page (input wr, input rd, input ofs, input wdata,
                  output rdata, output enable, output ratio);
endinterface : ddc_page_if

// ===== ddc_page_regs.sv
/*
 * One channel's decimation page: downconverter enable and decimation ratio.
 * Assumes the hub presents window-relative offsets and one-cycle strobes.
 */
`timescale 1ns/10ps
`include "serdes_sync_ddc_defines.svh"

module ddc_page_regs (
    input  wire logic   ref_clk_in,
    input  wire logic   rstn_in,
    ddc_page_if.page    pg
);

    logic                               enable_ff;
    serdes_sync_ddc_pkg::decim_code_t   ratio_ff;
    serdes_sync_ddc_pkg::decim_code_t   nxt_ratio;

    assign nxt_ratio = pg.wdata[`DECIM_RATIO_LSB +: `DECIM_RATIO_W];

    // Enable bit: 0 is bypass with the downconverter off
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            enable_ff <= `DDC_ENABLE_RST;
        end else if (pg.wr && pg.ofs == `DDC_ENABLE_OFS) begin
            enable_ff <= pg.wdata[`DDC_ENABLE_BIT];
        end
    end

    // Ratio field; unused and ambiguous codes leave the old ratio in force,
    // so a bad write can never put the filter into an undefined setting
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ratio_ff <= `DECIM_RATIO_RST;
        end else if (pg.wr && pg.ofs == `DECIM_RATIO_OFS &&
                     serdes_sync_ddc_pkg::decim_code_ok(nxt_ratio)) begin
            ratio_ff <= nxt_ratio;
        end
    end

    // Read mux, live only under the read strobe; reserved bits read zero
    always_comb begin
        pg.rdata = 8'h00;
        if (pg.rd) begin
            case (pg.ofs)
                `DDC_ENABLE_OFS:  pg.rdata = {7'h00, enable_ff};
                `DECIM_RATIO_OFS: pg.rdata = {4'h0, ratio_ff};
                default:          pg.rdata = 8'h00;
            endcase
        end
    end

    assign pg.enable = enable_ff;
    assign pg.ratio  = ratio_ff;

endmodule : ddc_page_regs

// ===== serdes_sync_ddc_config_regs.sv
/*
 * Configuration registers: serial PLL multiplier, SYSREF masking toward the
 * input clock divider and the oscillator / LMFC counter, and two decimation
 * pages. Assumes a synchronous register port and a synchronous SYSREF input.
 */
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "serdes_sync_ddc_defines.svh"

module serdes_sync_ddc_config_regs #(
    parameter int CLKDIV_RATIO = 4,
    parameter int LMFC_PERIOD  = 32
) (
    input  wire logic           ref_clk_in,
    input  wire logic           rstn_in,
    input  wire logic [15:0]    addr_in,
    input  wire logic [7:0]     wdata_in,
    input  wire logic           wr_in,
    input  wire logic           rd_in,
    output logic [7:0]          rdata_out,
    input  wire logic           sysref_in,
    output logic [1:0]          pll_mult_code_out,
    output logic [6:0]          pll_mult_factor_out,
    output logic                clkdiv_reset_out,
    output logic                clkdiv_tick_out,
    output logic                osc_phase_reset_out,
    output logic                lmfc_reset_out,
    output logic                lmfc_boundary_out,
    output logic [1:0]          ddc_enable_out,
    output logic [3:0]          decim_ratio_a_out,
    output logic [3:0]          decim_ratio_b_out,
    output logic [5:0]          decimation_ratio_a_out,
    output logic [5:0]          decimation_ratio_b_out
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam int CDW = (CLKDIV_RATIO > 1) ? $clog2(CLKDIV_RATIO) : 1;
    localparam int LMW = (LMFC_PERIOD > 1) ? $clog2(LMFC_PERIOD) : 1;
    localparam logic [CDW-1:0] CLKDIV_LAST = CDW'(CLKDIV_RATIO - 1);
    localparam logic [LMW-1:0] LMFC_LAST   = LMW'(LMFC_PERIOD - 1);

    // Page window decode, shared by both channels
    function automatic logic in_page(input logic [15:0] a, input logic [15:0] base);
        return ((a & `PAGE_WINDOW_MASK) == base);
    endfunction : in_page

    serdes_sync_ddc_pkg::pll_code_t pll_code_ff;
    logic                           div_mask_ff;
    logic                           osc_mask_ff;
    logic [7:0]                     rdata_ff;
    logic [7:0]                     nxt_rdata;
    logic                           sysref_q_ff;
    logic                           sysref_rise;
    logic                           div_sync;
    logic                           osc_sync;
    logic                           clkdiv_reset_ff;
    logic                           osc_reset_ff;
    logic                           lmfc_reset_ff;
    logic [CDW-1:0]                 clkdiv_cnt_ff;
    logic                           clkdiv_tick_ff;
    logic [LMW-1:0]                 lmfc_cnt_ff;
    logic                           lmfc_bound_ff;
    logic [6:0]                     pll_factor_ff;
    logic [5:0]                     factor_a_ff;
    logic [5:0]                     factor_b_ff;
    logic                           hit_pll;
    logic                           hit_mask;
    logic                           hit_a;
    logic                           hit_b;

    // One carrier per channel page
    ddc_page_if page_a ();
    ddc_page_if page_b ();

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Each channel page is a 2 KiB window; low 11 bits are its offset
    // PLL and mask sit on a chosen link page base
    assign hit_pll  = (addr_in == (`JESD_PAGE_BASE | `SERIAL_PLL_MULT_OFS));
    assign hit_mask = (addr_in == (`JESD_PAGE_BASE | `SYNC_PULSE_MASK_OFS));
    assign hit_a    = in_page(addr_in, `DDC_PAGE_BASE_A);
    assign hit_b    = in_page(addr_in, `DDC_PAGE_BASE_B);

    // Strobes are handed only to the page whose window matched
    assign page_a.wr    = wr_in & hit_a;
    assign page_a.rd    = rd_in & hit_a;
    assign page_a.ofs   = addr_in[10:0];
    assign page_a.wdata = wdata_in;
    assign page_b.wr    = wr_in & hit_b;
    assign page_b.rd    = rd_in & hit_b;
    assign page_b.ofs   = addr_in[10:0];
    assign page_b.wdata = wdata_in;

    // ------------------------------------------------------------------------
    // Decimation pages, one per channel
    // ------------------------------------------------------------------------
    // Identical pages; only their window differs
    ddc_page_regs u_page_a (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pg         (page_a.page)
    );

    ddc_page_regs u_page_b (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pg         (page_b.page)
    );

    // ------------------------------------------------------------------------
    // Serial PLL multiplier
    // ------------------------------------------------------------------------
    // The quad-rate assist field lives elsewhere; 40X is only valid once
    // software has set it too, which this block cannot check
    // Bits 7:2 are never stored and read back zero
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            pll_code_ff <= `PLL_MULT_RST;
        end else if (wr_in && hit_pll) begin
            pll_code_ff <= wdata_in[`PLL_MULT_LSB +: `PLL_MULT_W];
        end
    end

    // Factor decode registered so the output is a flop
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            pll_factor_ff <= `PLL_FACTOR_00;
        end else begin
            case (pll_code_ff)
                2'h0:    pll_factor_ff <= `PLL_FACTOR_00;
                2'h1:    pll_factor_ff <= `PLL_FACTOR_01;
                2'h2:    pll_factor_ff <= `PLL_FACTOR_10;
                2'h3:    pll_factor_ff <= `PLL_FACTOR_11;
                default: pll_factor_ff <= `PLL_FACTOR_00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // SYSREF mask bits
    // ------------------------------------------------------------------------
    // One write updates both masks together;
    // reserved bits of that write are dropped
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            div_mask_ff <= `SYNC_MASK_RST;
            osc_mask_ff <= `SYNC_MASK_RST;
        end else if (wr_in && hit_mask) begin
            div_mask_ff <= wdata_in[`DIV_SYNC_MASK_BIT];
            osc_mask_ff <= wdata_in[`OSC_SYNC_MASK_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // SYSREF edge detection and gating
    // ------------------------------------------------------------------------
    // Only the low-to-high transition counts; a held-high SYSREF fires once
    // SYSREF is taken as synchronous here;
    // an async source needs a synchroniser
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            sysref_q_ff <= 1'b0;
        end else begin
            sysref_q_ff <= sysref_in;
        end
    end

    assign sysref_rise = sysref_in & ~sysref_q_ff;
    assign div_sync    = sysref_rise & ~div_mask_ff;
    assign osc_sync    = sysref_rise & ~osc_mask_ff;

    // One-cycle reset pulses toward the divider, oscillators and LMFC
    // LMFC reset follows the oscillator mask
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            clkdiv_reset_ff <= 1'b0;
            osc_reset_ff    <= 1'b0;
            lmfc_reset_ff   <= 1'b0;
        end else begin
            clkdiv_reset_ff <= div_sync;
            osc_reset_ff    <= osc_sync;
            lmfc_reset_ff   <= osc_sync;
        end
    end

    // ------------------------------------------------------------------------
    // Input clock divider
    // ------------------------------------------------------------------------
    // Restarts at zero on an unmasked edge so that dividers in several
    // devices line up; masked, it keeps its phase across SYSREF
    // Limitation: tick is an enable, not a clock
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            clkdiv_cnt_ff  <= '0;
            clkdiv_tick_ff <= 1'b0;
        end else if (div_sync) begin
            clkdiv_cnt_ff  <= '0;
            clkdiv_tick_ff <= 1'b0;
        end else begin
            clkdiv_tick_ff <= (clkdiv_cnt_ff == CLKDIV_LAST);
            clkdiv_cnt_ff  <= (clkdiv_cnt_ff == CLKDIV_LAST) ? '0 :
                              clkdiv_cnt_ff + CDW'(1);
        end
    end

    // ------------------------------------------------------------------------
    // LMFC counter
    // ------------------------------------------------------------------------
    // Boundary is high in the cycle after the last count of a period;
    // masked, the phase survives SYSREF
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            lmfc_cnt_ff   <= '0;
            lmfc_bound_ff <= 1'b0;
        end else if (osc_sync) begin
            lmfc_cnt_ff   <= '0;
            lmfc_bound_ff <= 1'b0;
        end else begin
            lmfc_bound_ff <= (lmfc_cnt_ff == LMFC_LAST);
            lmfc_cnt_ff   <= (lmfc_cnt_ff == LMFC_LAST) ? '0 :
                             lmfc_cnt_ff + LMW'(1);
        end
    end

    // ------------------------------------------------------------------------
    // Decimation factor outputs
    // ------------------------------------------------------------------------
    // One cycle of lag keeps each output a flop;
    // the ratio only moves on a register write
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            factor_a_ff <= serdes_sync_ddc_pkg::decimation_ratio(`DECIM_RATIO_RST);
            factor_b_ff <= serdes_sync_ddc_pkg::decimation_ratio(`DECIM_RATIO_RST);
        end else begin
            factor_a_ff <= serdes_sync_ddc_pkg::decimation_ratio(page_a.ratio);
            factor_b_ff <= serdes_sync_ddc_pkg::decimation_ratio(page_b.ratio);
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Unmapped addresses and reserved bits read as zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit_pll) begin
            nxt_rdata = {6'h00, pll_code_ff};
        end else if (hit_mask) begin
            nxt_rdata = {1'b0, div_mask_ff, osc_mask_ff, 5'h00};
        end else if (hit_a) begin
            nxt_rdata = page_a.rdata;
        end else if (hit_b) begin
            nxt_rdata = page_b.rdata;
        end
    end

    // Data stand only in the cycle after the read strobe
    // Gating on rd_in keeps the bus at zero
    // between reads, so stale data never linger
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            rdata_ff <= `RDATA_RST;
        end else begin
            rdata_ff <= rd_in ? nxt_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Each output is a flop here or in a page
    assign rdata_out           = rdata_ff;
    assign pll_mult_code_out   = pll_code_ff;
    assign pll_mult_factor_out = pll_factor_ff;
    assign clkdiv_reset_out    = clkdiv_reset_ff;
    assign clkdiv_tick_out     = clkdiv_tick_ff;
    assign osc_phase_reset_out = osc_reset_ff;
    assign lmfc_reset_out      = lmfc_reset_ff;
    assign lmfc_boundary_out   = lmfc_bound_ff;
    assign ddc_enable_out      = {page_b.enable, page_a.enable};
    assign decim_ratio_a_out   = page_a.ratio;
    assign decim_ratio_b_out   = page_b.ratio;
    assign decimation_ratio_a_out  = factor_a_ff;
    assign decimation_ratio_b_out  = factor_b_ff;

endmodule : serdes_sync_ddc_config_regs

// ===== serdes_sync_ddc_config_regs_properties.sv
/*
 * Concurrent checks of the configuration register block.
 * Assumes it is bound to the block's top and sees its ports only.
 */
`timescale 1ns/10ps

module serdes_sync_ddc_props #(
    parameter int CLKDIV_RATIO = 4,
    parameter int LMFC_PERIOD  = 32
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [7:0]  rdata_out,
    input  wire logic        sysref_in,
    input  wire logic [1:0]  pll_mult_code_out,
    input  wire logic [6:0]  pll_mult_factor_out,
    input  wire logic        clkdiv_reset_out,
    input  wire logic        osc_phase_reset_out,
    input  wire logic        lmfc_reset_out,
    input  wire logic [1:0]  ddc_enable_out,
    input  wire logic [3:0]  decim_ratio_a_out,
    input  wire logic [3:0]  decim_ratio_b_out,
    input  wire logic [5:0]  decimation_ratio_a_out
);
    // ------------------------------------------------------------------------
    // Reference tables and mask shadow
    // ------------------------------------------------------------------------
    // Zero marks a ratio code that must never be accepted
    localparam logic [5:0] fac_tbl [16] = '{6'h04, 6'h06, 6'h08, 6'h09, 6'h0A,
        6'h0C, 6'h00, 6'h00, 6'h00, 6'h14, 6'h00, 6'h00, 6'h20, 6'h00, 6'h00, 6'h00};
    localparam logic [6:0] pll_tbl [4] = '{7'h14, 7'h10, 7'h28, 7'h50};
    logic [1:0] msk_ff; // [1] divider, [0] oscillator

    // Shadow of the mask bits, so SYSREF checks need no internal probe
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) msk_ff <= 2'h0;
        else if (wr_in && addr_in == 16'h603E) msk_ff <= wdata_in[6:5];
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_pll; $past(rstn_in) |-> pll_mult_factor_out == pll_tbl[$past(pll_mult_code_out)];
    endproperty
    a_pll: assert property (p_pll) else $error("pll factor off");
    property p_div_sync; $rose(sysref_in) && !msk_ff[1] |=> clkdiv_reset_out; endproperty
    a_div_sync: assert property (p_div_sync) else $error("divider not reset");
    property p_div_mask;
        clkdiv_reset_out |-> $past(sysref_in) && !$past(sysref_in, 2) && !$past(msk_ff[1]);
    endproperty
    a_div_mask: assert property (p_div_mask) else $error("stray divider reset");
    property p_osc_sync;
        $rose(sysref_in) && !msk_ff[0] |=> osc_phase_reset_out && lmfc_reset_out;
    endproperty
    a_osc_sync: assert property (p_osc_sync) else $error("oscillator not reset");
    property p_osc_mask;
        $rose(sysref_in) && msk_ff[0] |=> !osc_phase_reset_out && !lmfc_reset_out;
    endproperty
    a_osc_mask: assert property (p_osc_mask) else $error("masked edge acted");
    property p_unmapped; rd_in && addr_in[15:12] == 4'h1 |=> rdata_out == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
    property p_enable_b; wr_in && addr_in == 16'h5800 |=> ddc_enable_out[1] == $past(wdata_in[0]);
    endproperty
    a_enable_b: assert property (p_enable_b) else $error("enable b wrong");
    property p_factor; $past(rstn_in) |-> decimation_ratio_a_out == fac_tbl[$past(decim_ratio_a_out)];
    endproperty
    a_factor: assert property (p_factor) else $error("decimation factor off");
    property p_ratio_wr;
        wr_in && addr_in == 16'h5001 |=> decim_ratio_a_out == ((fac_tbl[$past(wdata_in[3:0])]
            != 6'h00) ? $past(wdata_in[3:0]) : $past(decim_ratio_a_out));
    endproperty
    a_ratio_wr: assert property (p_ratio_wr) else $error("ratio write wrong");
    property p_legal; fac_tbl[decim_ratio_a_out] != 6'h00 && fac_tbl[decim_ratio_b_out] != 6'h00;
    endproperty
    a_legal: assert property (p_legal) else $error("reserved ratio held");
    property p_rsvd; rd_in && addr_in == 16'h603E |=> rdata_out[7] == 1'b0 && rdata_out[4:0] == 5'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
endmodule : serdes_sync_ddc_props

bind serdes_sync_ddc_config_regs serdes_sync_ddc_props #(
    .CLKDIV_RATIO(CLKDIV_RATIO), .LMFC_PERIOD(LMFC_PERIOD)) u_props (.*);

// ===== serdes_sync_ddc_config_regs_tb.sv
/*
 * Self-checking bench for the configuration register block.
 * Assumes the property checker is compiled beside it and bound.
 */
`timescale 1ns/10ps

module serdes_sync_ddc_config_regs_tb;
    logic        ref_clk, rstn, wr, rd, sysref;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata;
    logic [1:0]  pll_code, downconverter_enable;
    logic [6:0]  pll_fac;
    logic        div_rst, div_tick, osc_rst, lmfc_rst, lmfc_bnd;
    logic [3:0]  ratio_a, ratio_b, exp_r;
    logic [5:0]  fac_a, fac_b;
    int          n_mismatch = 0;
    int          compares = 0;
    logic [15:0] regs [6] = '{16'h6037, 16'h603E, 16'h5000, 16'h5001, 16'h5800, 16'h5801};
    logic [7:0]  pll_tbl [4] = '{8'h14, 8'h10, 8'h28, 8'h50};
    logic [7:0]  fac_tbl [16] = '{8'h04, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h00, 8'h00,
                                  8'h00, 8'h14, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};

    // Short LMFC period keeps boundaries frequent in a short run
    serdes_sync_ddc_config_regs #(.CLKDIV_RATIO(4), .LMFC_PERIOD(8)) uut (
        .ref_clk_in(ref_clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sysref_in(sysref),
        .pll_mult_code_out(pll_code), .pll_mult_factor_out(pll_fac),
        .clkdiv_reset_out(div_rst), .clkdiv_tick_out(div_tick),
        .osc_phase_reset_out(osc_rst), .lmfc_reset_out(lmfc_rst),
        .lmfc_boundary_out(lmfc_bnd), .ddc_enable_out(downconverter_enable),
        .decim_ratio_a_out(ratio_a), .decim_ratio_b_out(ratio_b),
        .decimation_ratio_a_out(fac_a), .decimation_ratio_b_out(fac_b));

    // ------------------------------------------------------------------------
    // Clock, bus tasks and verdict
    // ------------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle strobe; the write lands at the edge that samples it
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 check(rdata, exp, what);
    endtask : rd_reg

    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        sysref = 1'b0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        foreach (regs[i]) rd_reg(regs[i], 8'h00, "reset value");
        check(8'(pll_fac), 8'h14, "pll factor reset");
        check(8'(fac_a), 8'h04, "factor reset");
        // Every PLL code, reserved bits set to prove they are dropped
        for (int c = 3; c >= 0; c--) begin
            wr_reg(16'h6016, (c == 2) ? 8'h70 : 8'h00);
            wr_reg(16'h6037, {6'h3F, 2'(c)});
            #1 check(8'(pll_code), 8'(c), "pll code");
            @(posedge ref_clk);
            #1 check(8'(pll_fac), pll_tbl[c], "pll factor");
            rd_reg(16'h6037, 8'(c), "pll readback");
        end
        // All sixteen ratio codes; refused ones must keep the old code
        exp_r = 4'h0;
        for (int c = 0; c < 16; c++) begin
            wr_reg(16'h5001, {4'hF, 4'(c)});
            if (fac_tbl[c] != 8'h00) exp_r = 4'(c);
            #1 check(8'(ratio_a), 8'(exp_r), "ratio a");
            @(posedge ref_clk);
            #1 check(8'(fac_a), fac_tbl[exp_r], "factor a");
            rd_reg(16'h5001, 8'(exp_r), "ratio readback");
        end
        // Second channel decoded apart; an unmapped write changes nothing
        wr_reg(16'h5000, 8'hFF);
        wr_reg(16'h5800, 8'h01);
        wr_reg(16'h5801, 8'h09);
        wr_reg(16'h5000, 8'h00);
        wr_reg(16'h1234, 8'hFF);
        @(posedge ref_clk);
        #1 check(8'(downconverter_enable), 8'h02, "enable");
        check(8'(ratio_b), 8'h09, "ratio b");
        check(8'(ratio_a), 8'h0C, "ratio a kept");
        check(8'(fac_b), 8'h14, "factor b");
        rd_reg(16'h5800, 8'h01, "enable b");
        rd_reg(16'h1234, 8'h00, "unmapped");
        // Each mask setting against one SYSREF rise held high
        for (int m = 0; m < 4; m++) begin
            wr_reg(16'h603E, {1'b1, 2'(m), 5'h1F});
            rd_reg(16'h603E, {1'b0, 2'(m), 5'h00}, "mask readback");
            sysref <= 1'b1;
            @(posedge ref_clk);
            #1 check(8'(div_rst), 8'(!m[1]), "divider reset");
            check(8'(osc_rst), 8'(!m[0]), "oscillator reset");
            check(8'(lmfc_rst), 8'(!m[0]), "lmfc reset");
            @(posedge ref_clk);
            #1 check(8'(div_rst | osc_rst), 8'h00, "held sysref");
            sysref <= 1'b0;
            // Restarted counters peak here; a 13-cycle loop keeps masked ones off it
            repeat (3) @(posedge ref_clk);
            #1 check(8'(div_tick), 8'(!m[1]), "divider tick");
            repeat (4) @(posedge ref_clk);
            #1 check(8'(lmfc_bnd), 8'(!m[0]), "lmfc boundary");
        end
        stop_test();
    end
endmodule : serdes_sync_ddc_config_regs_tb
